/* tsso_bus_model.sv */
// Backplane model: free-running transmit bus clock and supplied sync pulses
module tsso_bus_model (
  // Request from the bench
  input wire logic send,
  // Bus pins
  output logic tsb_clk,
  output logic fs = 1'b0,
  output logic mf = 1'b0,
  // Bus bits counted since the last supplied pulse ended
  output logic [7:0] bits_after = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;

  logic busy_q = 1'b0;

  // ----------------------------------------------------------------
  // Bus clock and sync drive
  // ----------------------------------------------------------------
  // A TDM bus clock runs free; the odd start keeps it out of phase with clk
  initial
  begin
    tsb_clk = 1'b0;
    #37;
    forever #400 tsb_clk = ~tsb_clk;
  end

  // Syncs change on the rising edge so the device samples them mid-bit
  always @(posedge tsb_clk)
  begin
    if (fs)
    begin
      fs <= 1'b0;
      mf <= 1'b0;
      bits_after <= 8'h00;
    end
    else if (send && !busy_q)
    begin
      fs <= 1'b1;
      mf <= 1'b1;
      busy_q <= 1'b1;
    end
    else
    begin
      bits_after <= bits_after + 8'h01;
    end
    // One pulse per request, however long the bench holds it
    if (!send)
    begin
      busy_q <= 1'b0;
    end
  end
endmodule

/* tsso_link_sync.sv */
// Synchroniser and edge finder for the transmit system bus clock and sync inputs
module tsso_link_sync
  import tsso_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pins from the system bus side
  input wire logic tsb_clk,
  input wire logic fs_pin,
  input wire logic mf_pin,
  // Synchronised results
  output logic rise_en,
  output logic fall_en,
  output logic fs_lvl,
  output logic mf_lvl
);
  logic [2:0] ck_q;
  logic [1:0] fs_q;
  logic [1:0] mf_q;

  // Two stages before use; the third stage only serves edge finding
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ck_q <= 3'h0;
      fs_q <= 2'h0;
      mf_q <= 2'h0;
    end
    else
    begin
      ck_q <= {ck_q[1:0], tsb_clk};
      fs_q <= {fs_q[0], fs_pin};
      mf_q <= {mf_q[0], mf_pin};
    end
  end

  // Edges are read from stages two and three only
  assign rise_en = ck_q[1] & ~ck_q[2];
  assign fall_en = ~ck_q[1] & ck_q[2];
  assign fs_lvl = fs_q[1];
  assign mf_lvl = mf_q[1];
endmodule

/* tsso_pkg.sv */
// Types shared by the sync offset block
package tsso_pkg;
  // System bus rate selection
  typedef enum logic [2:0] {
    TSSO_R1536,
    TSSO_R1544,
    TSSO_R2048,
    TSSO_R4096,
    TSSO_R8192
  } tsso_rate_t;
  // Running bit position within a bus frame
  typedef logic [9:0] tsso_pos_t;
endpackage

/* tsso_regs.svh */
// Register offsets, field positions, reset values and frame counts for the sync offset block
`ifndef TSSO_REGS_SVH
`define TSSO_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TSSO_ADDR_CFG 8'hd0
`define TSSO_ADDR_POS_LO 8'hd1
`define TSSO_ADDR_POS_HI 8'hd2
`define TSSO_ADDR_BIT 8'hd5
`define TSSO_ADDR_SLOT 8'hd6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TSSO_CFG_RATE_MSB 2
`define TSSO_CFG_ACCEPT 3
`define TSSO_CFG_ENABLE 4
`define TSSO_BIT_W 3
`define TSSO_SLOT_W 7
`define TSSO_POS_W 10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TSSO_CFG_RST 8'h00
`define TSSO_BIT_RST 3'h0
`define TSSO_SLOT_RST 7'h00

// ----------------------------------------------------------------
// Frame and multiframe lengths
// ----------------------------------------------------------------
`define TSSO_BITS_1536 11'd192
`define TSSO_BITS_1544 11'd193
`define TSSO_BITS_2048 11'd256
`define TSSO_BITS_4096 11'd512
`define TSSO_BITS_8192 11'd1024
`define TSSO_MF_T1 5'd24
`define TSSO_MF_E1 5'd16

`endif

/* tsso_top.sv */
// Transmit system bus frame and multiframe sync placement at a programmable offset
// Function
// - 3-bit bit offset picks the bit; 000 is bit 1 or F-bit, 111 bit 8
// - Slot and bit offsets join into one 10-bit position for both syncs
// - 7-bit slot offset forms position bits 9 to 3, slots 0 to 127
// - At 1536, 1544, 2048 kbps the whole slot field is the slot number
// - At 4096 kbps upper six bits are the slot, lowest bit picks group
// - At 8192 kbps upper five bits are the slot, two lowest pick group
// - A position outside the bus frame gives no sync pulses at all
// - Sync position aligns to one bit against the transmit stream slots
// - Device or system may drive the syncs, always at the programmed position
//
// The implementer's own choice: the address-and-strobe port.
`include "tsso_regs.svh"
module tsso_top
  import tsso_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Transmit system bus clock
  input wire logic tx_system_bus_clk,
  // Frame sync pin
  input wire logic tx_frame_sync_i,
  output logic tx_frame_sync_o,
  output logic tx_frame_sync_oe,
  // Multiframe sync pin
  input wire logic tx_multiframe_sync_i,
  output logic tx_multiframe_sync_o,
  output logic tx_multiframe_sync_oe
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Bus frame length in bits for a rate; unknown codes fall back to 2048
  function automatic logic [10:0] frame_bits(input tsso_rate_t r);
    unique case (r)
      TSSO_R1536: frame_bits = `TSSO_BITS_1536;
      TSSO_R1544: frame_bits = `TSSO_BITS_1544;
      TSSO_R4096: frame_bits = `TSSO_BITS_4096;
      TSSO_R8192: frame_bits = `TSSO_BITS_8192;
      default: frame_bits = `TSSO_BITS_2048;
    endcase
  endfunction

  // Following bit position, wrapping at the frame end
  function automatic tsso_pos_t next_pos(input tsso_pos_t p, input tsso_rate_t r);
    logic [10:0] n;
    n = {1'b0, p} + 11'd1;
    next_pos = (n >= frame_bits(r)) ? 10'h000 : n[9:0];
  endfunction

  // Frames per multiframe: T1 rates use 24, the rest 16
  function automatic logic [4:0] mf_frames(input tsso_rate_t r);
    mf_frames = (r == TSSO_R1536 || r == TSSO_R1544) ? `TSSO_MF_T1 : `TSSO_MF_E1;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] cfg_q;
  logic [2:0] tx_sync_bit_offset_q;
  logic [6:0] tx_sync_slot_offset_q;
  tsso_rate_t rate;
  logic accept;
  logic enable;

  // Only defined bits are kept, so reserved bits always read back as zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_q <= `TSSO_CFG_RST;
      tx_sync_bit_offset_q <= `TSSO_BIT_RST;
      tx_sync_slot_offset_q <= `TSSO_SLOT_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `TSSO_ADDR_CFG)
        cfg_q <= {3'h0, reg_wdata[4:0]};
      if (reg_addr == `TSSO_ADDR_BIT)
        tx_sync_bit_offset_q <= reg_wdata[2:0];
      if (reg_addr == `TSSO_ADDR_SLOT)
        tx_sync_slot_offset_q <= reg_wdata[6:0];
    end
  end

  assign rate = tsso_rate_t'(cfg_q[`TSSO_CFG_RATE_MSB:0]);
  assign accept = cfg_q[`TSSO_CFG_ACCEPT];
  assign enable = cfg_q[`TSSO_CFG_ENABLE];

  // ----------------------------------------------------------------
  // Programmed position
  // ----------------------------------------------------------------
  tsso_pos_t offset_pos;
  logic in_range;

  // Slot sits above bit; at 4096 and 8192 the group bits fall in the low
  // slot bits, so bus slot = slot * groups + group and the join still holds
  assign offset_pos = {tx_sync_slot_offset_q, tx_sync_bit_offset_q};

  // Position must lie inside the bus frame for the chosen rate
  always_comb
  begin
    unique case (rate)
      TSSO_R1536: in_range = ({1'b0, offset_pos} < `TSSO_BITS_1536);
      TSSO_R1544: in_range = ({1'b0, offset_pos} < `TSSO_BITS_1544);
      TSSO_R4096: in_range = ({1'b0, offset_pos} < `TSSO_BITS_4096);
      TSSO_R8192: in_range = ({1'b0, offset_pos} < `TSSO_BITS_8192);
      default: in_range = ({1'b0, offset_pos} < `TSSO_BITS_2048);
    endcase
  end

  // ----------------------------------------------------------------
  // Link clock sampling
  // ----------------------------------------------------------------
  logic bit_en;
  logic mid_en;
  logic fs_lvl;
  logic mf_lvl;

  tsso_link_sync u_link (
    .clk(clk),
    .reset_n(reset_n),
    .tsb_clk(tx_system_bus_clk),
    .fs_pin(tx_frame_sync_i),
    .mf_pin(tx_multiframe_sync_i),
    .rise_en(bit_en),
    .fall_en(mid_en),
    .fs_lvl(fs_lvl),
    .mf_lvl(mf_lvl)
  );

  // Incoming syncs are taken mid-bit, away from the edge where they change
  logic fs_smp_q;
  logic mf_smp_q;
  logic fs_prev_q;
  logic mf_prev_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fs_smp_q <= 1'b0;
      mf_smp_q <= 1'b0;
    end
    else if (mid_en)
    begin
      fs_smp_q <= fs_lvl;
      mf_smp_q <= mf_lvl;
    end
  end

  // Previous bit's sample, for leading edge detection
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fs_prev_q <= 1'b0;
      mf_prev_q <= 1'b0;
    end
    else if (bit_en)
    begin
      fs_prev_q <= fs_smp_q;
      mf_prev_q <= mf_smp_q;
    end
  end

  logic fs_lead;
  logic mf_lead;
  logic realign;
  assign fs_lead = fs_smp_q & ~fs_prev_q;
  assign mf_lead = mf_smp_q & ~mf_prev_q;
  // An out-of-frame offset cannot be honoured, so it never moves the timebase
  assign realign = enable & accept & in_range & fs_lead;

  // ----------------------------------------------------------------
  // Bit and frame timebase
  // ----------------------------------------------------------------
  tsso_pos_t pos_q;
  tsso_pos_t pos_d;
  logic [4:0] frm_q;
  logic [4:0] frm_d;

  // Next bit; an accepted sync marks the bit just ended as the offset bit
  always_comb
  begin
    if (realign)
      pos_d = next_pos(offset_pos, rate);
    else
      pos_d = next_pos(pos_q, rate);
  end

  // Frame count advances when the bit position wraps to zero
  always_comb
  begin
    frm_d = frm_q;
    if (realign && mf_lead)
      frm_d = (pos_d == 10'h000) ? 5'd1 : 5'd0;
    else if (pos_d == 10'h000)
      frm_d = (frm_q + 5'd1 >= mf_frames(rate)) ? 5'd0 : frm_q + 5'd1;
  end

  // Running bit position counts on every bus clock rising edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pos_q <= 10'h000;
      frm_q <= 5'd0;
    end
    else if (bit_en)
    begin
      pos_q <= pos_d;
      frm_q <= frm_d;
    end
  end

  // ----------------------------------------------------------------
  // Sync pin drive
  // ----------------------------------------------------------------
  logic drive;
  assign drive = enable & ~accept;

  // Pulse covers exactly the bit whose position equals the offset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_frame_sync_o <= 1'b0;
      tx_multiframe_sync_o <= 1'b0;
    end
    // An offset moved out of the frame also cuts a pulse already standing
    else if (!drive || !in_range)
    begin
      tx_frame_sync_o <= 1'b0;
      tx_multiframe_sync_o <= 1'b0;
    end
    else if (bit_en)
    begin
      tx_frame_sync_o <= in_range && (pos_d == offset_pos);
      tx_multiframe_sync_o <= in_range && (pos_d == offset_pos) && (frm_d == 5'd0);
    end
  end

  // Enables follow direction; the pins are released while accepting
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_frame_sync_oe <= 1'b0;
      tx_multiframe_sync_oe <= 1'b0;
    end
    else
    begin
      tx_frame_sync_oe <= drive;
      tx_multiframe_sync_oe <= drive;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------

  // Data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `TSSO_ADDR_CFG: reg_rdata <= cfg_q;
        `TSSO_ADDR_POS_LO: reg_rdata <= pos_q[7:0];
        `TSSO_ADDR_POS_HI: reg_rdata <= {1'b0, frm_q, pos_q[9:8]};
        `TSSO_ADDR_BIT: reg_rdata <= {5'h00, tx_sync_bit_offset_q};
        `TSSO_ADDR_SLOT: reg_rdata <= {1'b0, tx_sync_slot_offset_q};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  bit_store_a: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr && reg_addr == `TSSO_ADDR_BIT |=> tx_sync_bit_offset_q == $past(reg_wdata[2:0]))
    else $error("bit offset write not stored");

  slot_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == `TSSO_ADDR_SLOT && !reg_wr
      |=> reg_rdata == {1'b0, tx_sync_slot_offset_q})
    else $error("slot offset read back wrong");

  pulse_place_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(tx_frame_sync_o) |-> pos_q == offset_pos)
    else $error("frame sync not at programmed position");

  out_range_a: assert property (@(posedge clk) disable iff (!reset_n)
    !in_range && $past(!in_range) && $past(!in_range, 2)
      |-> !tx_frame_sync_o && !tx_multiframe_sync_o)
    else $error("sync pulse from out-of-frame offset");

  low_rate_a: assert property (@(posedge clk) disable iff (!reset_n)
    rate == TSSO_R2048 |-> in_range == (tx_sync_slot_offset_q < 7'd32))
    else $error("2048 slot range wrong");

  group_two_a: assert property (@(posedge clk) disable iff (!reset_n)
    rate == TSSO_R4096 |-> in_range == !tx_sync_slot_offset_q[6])
    else $error("4096 slot range wrong");

  group_four_a: assert property (@(posedge clk) disable iff (!reset_n)
    rate == TSSO_R8192 |-> in_range)
    else $error("8192 offset wrongly out of frame");

  pulse_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    tx_frame_sync_o && !bit_en && drive && in_range |=> tx_frame_sync_o)
    else $error("frame sync shorter than one bit");

  pulse_end_a: assert property (@(posedge clk) disable iff (!reset_n)
    tx_frame_sync_o && bit_en && $stable(offset_pos) && !realign |=> !tx_frame_sync_o)
    else $error("frame sync longer than one bit");

  mf_inside_a: assert property (@(posedge clk) disable iff (!reset_n)
    tx_multiframe_sync_o |-> tx_frame_sync_o)
    else $error("multiframe sync off frame sync position");

  realign_pos_a: assert property (@(posedge clk) disable iff (!reset_n)
    bit_en && realign |=> pos_q == next_pos($past(offset_pos), $past(rate)))
    else $error("timebase not realigned to accepted sync");

  pin_dir_a: assert property (@(posedge clk) disable iff (!reset_n)
    accept ##1 accept |-> !tx_frame_sync_oe && !tx_multiframe_sync_oe)
    else $error("sync pins driven while accepting");

endmodule

/* tx_system_bus_sync_offset_tb.sv */
// Self-checking bench for the transmit bus sync offset block
`include "tsso_regs.svh"
module tx_system_bus_sync_offset_tb
  import tsso_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  localparam int LIMIT = 90000;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic tsb_clk, sys_fs, sys_mf, fs_o, fs_oe, mf_o, mf_oe;
  logic send = 1'b0;
  logic [7:0] bits_after;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  tsso_rate_t rates [10] = '{TSSO_R1536, TSSO_R1544, TSSO_R2048, TSSO_R4096, TSSO_R8192,
    TSSO_R2048, TSSO_R1536, TSSO_R1544, TSSO_R2048, TSSO_R4096};
  int bits [10] = '{192, 193, 256, 512, 1024, 256, 192, 193, 256, 512};
  logic [9:0] offs [10] = '{10'd191, 10'd192, 10'd255, 10'd511, 10'd1023, 10'd0,
    10'd192, 10'd193, 10'd256, 10'd512};

  // ----------------------------------------------------------------
  // Clock, design and backplane
  // ----------------------------------------------------------------
  always #50 clk = ~clk;

  tsso_top DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_system_bus_clk(tsb_clk),
    .tx_frame_sync_i(sys_fs), .tx_frame_sync_o(fs_o), .tx_frame_sync_oe(fs_oe),
    .tx_multiframe_sync_i(sys_mf), .tx_multiframe_sync_o(mf_o),
    .tx_multiframe_sync_oe(mf_oe));

  tsso_bus_model bus (.send(send), .tsb_clk(tsb_clk), .fs(sys_fs), .mf(sys_mf),
    .bits_after(bits_after));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(v, exp);
  endtask

  // Samples just after each edge; n is -1 when no rising edge of the sync came
  task automatic wait_rise(input int lim, output int n);
    logic was;
    was = 1'b1;
    for (n = 1; n <= lim; n++)
    begin
      @(posedge clk);
      #1;
      if (fs_o === 1'b1 && was === 1'b0)
        return;
      was = fs_o;
    end
    n = -1;
  endtask

  // 0: supplied sync high, 1: supplied sync low, 2: five bits after the pulse
  task automatic wait_bus(input int what);
    int k;
    k = 0;
    while (!((what == 0 && sys_fs === 1'b1) || (what == 1 && sys_fs === 1'b0) ||
      (what == 2 && bits_after === 8'd5)) && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
    // A bus event that never comes counts against the run
    if (k >= 3000)
    begin
      mismatches++;
    end
  endtask

  // Multiframe sync may only ride on a frame sync; checked off the edge
  always @(negedge clk)
  begin
    if (mf_o === 1'b1)
      check(fs_o, 1'b1);
  end

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    int n;
    int w;
    logic [7:0] v;
    logic [9:0] ofs;
    logic [4:0] fr;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    // Register port: reset values, reserved bits, one-cycle read data, unmapped place
    rd_chk(`TSSO_ADDR_BIT, 8'h00);
    rd_chk(`TSSO_ADDR_SLOT, 8'h00);
    wr(`TSSO_ADDR_BIT, 8'hff);
    rd_chk(`TSSO_ADDR_BIT, 8'h07);
    @(posedge clk);
    #1 check(reg_rdata, 8'h00);
    wr(`TSSO_ADDR_SLOT, 8'hff);
    rd_chk(`TSSO_ADDR_SLOT, 8'h7f);
    wr(8'h10, 8'h5a);
    rd_chk(8'h10, 8'h00);
    // Device drives the syncs: every rate in range, and just-outside offsets at all rates but 8192
    for (int i = 0; i < 10; i++)
    begin
      wr(`TSSO_ADDR_CFG, 8'h00);
      wr(`TSSO_ADDR_BIT, {5'h00, offs[i][2:0]});
      wr(`TSSO_ADDR_SLOT, {1'b0, offs[i][9:3]});
      wr(`TSSO_ADDR_CFG, {3'h0, 2'b10, rates[i]});
      wait_rise(bits[i] * 16 + 100, n);
      if (i > 5)
      begin
        check(n[15:0], 16'hffff);
        continue;
      end
      check(fs_oe, 1'b1);
      check(mf_oe, 1'b1);
      // Frame number at this pulse; the read spends two of the pulse's cycles
      rd(`TSSO_ADDR_POS_HI, v);
      fr = v[6:2];
      w = 2;
      while (fs_o === 1'b1 && w < 40)
      begin
        @(posedge clk);
        #1;
        w++;
      end
      check(w[15:0], 16'd8);
      wait_rise(bits[i] * 8 + 100, n);
      check(16'(w + n), 16'(bits[i] * 8));
      // One frame later: frame number steps, multiframe sync only in frame 0
      fr = (fr + 5'd1 >= ((rates[i] == TSSO_R1536 || rates[i] == TSSO_R1544) ? `TSSO_MF_T1 :
        `TSSO_MF_E1)) ? 5'd0 : fr + 5'd1;
      check(mf_o, fr == 5'd0);
      rd_chk(`TSSO_ADDR_POS_LO, offs[i][7:0]);
      rd(`TSSO_ADDR_POS_HI, v);
      check(v[1:0], offs[i][9:8]);
      check(v[6:2], fr);
    end
    // System supplies the syncs: the timebase follows the programmed position
    for (int j = 0; j < 2; j++)
    begin
      ofs = (j == 1) ? 10'd1000 : 10'd100;
      wr(`TSSO_ADDR_CFG, 8'h00);
      wr(`TSSO_ADDR_BIT, {5'h00, ofs[2:0]});
      wr(`TSSO_ADDR_SLOT, {1'b0, ofs[9:3]});
      wr(`TSSO_ADDR_CFG, {3'h0, 2'b11, (j == 1) ? TSSO_R8192 : TSSO_R2048});
      send <= 1'b1;
      wait_bus(0);
      wait_bus(1);
      send <= 1'b0;
      wait_bus(2);
      repeat (5) @(posedge clk);
      ofs = ofs + 10'd6;
      rd_chk(`TSSO_ADDR_POS_LO, ofs[7:0]);
      rd_chk(`TSSO_ADDR_POS_HI, {6'h00, ofs[9:8]});
      check({fs_o, fs_oe, mf_o, mf_oe}, 4'h0);
    end
    report_and_stop();
  end
endmodule
